/* verilog/rcst_pkg.sv */
package rcst_pkg;

	// Clock and start-up timing
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned POWER_UP_TIMER_TIME_MS   = 72;
	localparam int unsigned RC_TICK_NS     = 1000;
	localparam int unsigned RC_DIV_DEF     = RC_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned POWER_UP_TIMER_TICKS_DEF = POWER_UP_TIMER_TIME_MS * 1000000 / RC_TICK_NS;
	localparam int unsigned OST_CYCLES     = 1024;
	localparam logic [10:0] OST_LAST       = 11'(OST_CYCLES - 1);
	localparam logic [7:0]  MASTER_CLEAR_PIN_FILT_DEF  = 8'h10;

	// APB map: printed indices, byte address is four times the index
	localparam int unsigned ADDR_W         = 12;
	localparam logic [7:0]  IDX_PWR_STATUS = 8'h8E;
	localparam logic [7:0]  IDX_CAUSE      = 8'h8F;
	localparam logic [7:0]  IDX_CTRL       = 8'h90;
	localparam logic [ADDR_W-1:0] ADR_PWR_STATUS = {2'h0, IDX_PWR_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_CAUSE      = {2'h0, IDX_CAUSE, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_CTRL       = {2'h0, IDX_CTRL, 2'h0};

	// Field positions
	localparam int unsigned PS_BO_BIT  = 0;
	localparam int unsigned PS_POR_BIT = 1;

	// Clock mode selection
	localparam logic [1:0] MODE_LP = 2'h0;
	localparam logic [1:0] MODE_XT = 2'h1;
	localparam logic [1:0] MODE_HS = 2'h2;
	localparam logic [1:0] MODE_RC = 2'h3;

	// Reset cause codes
	typedef enum logic [2:0] {
		CAUSE_POR       = 3'h0,
		CAUSE_MASTER_CLEAR_PIN_RUN  = 3'h1,
		CAUSE_MASTER_CLEAR_PIN_SLP  = 3'h2,
		CAUSE_WDT_RST   = 3'h3,
		CAUSE_WDT_WAKE  = 3'h4,
		CAUSE_BOR       = 3'h5,
		CAUSE_INT_WAKE  = 3'h6
	} rcst_cause_t;

	typedef enum logic [5:0] {
		ST_POR  = 6'h01,
		ST_BOR  = 6'h02,
		ST_POWER_UP_TIMER = 6'h04,
		ST_OST  = 6'h08,
		ST_HOLD = 6'h10,
		ST_RUN  = 6'h20
	} rcst_state_t;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} rcst_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} rcst_apb_rsp_t;

	typedef struct packed {
		logic        power_timer_disable_cfg;
		logic        brownout_enable_cfg;
		logic        clock_mode_bit_high;
		logic        clock_mode_bit_low;
	} rcst_cfg_t;

	typedef struct packed {
		logic [2:0]  por_s;
		logic [2:0]  bor_s;
		logic [2:0]  master_clear_pin_s;
		logic [2:0]  osc_s;
		logic        por_st;
		logic        bor_st;
		logic        master_clear_pin_st;
		logic        osc_st;
		logic [7:0]  filt_cnt;
		logic        master_clear_pin_low;
		rcst_state_t state;
		logic        wake;
		logic        wake_pulse;
		logic [15:0] rc_div;
		logic [31:0] power_up_timer_cnt;
		logic [10:0] ost_cnt;
		logic        timeout_flag;
		logic        sleep_flag;
		rcst_cause_t cause;
		logic        brownout_flag;
		logic        por_flag;
		logic [7:0]  filt_len;
		logic [31:0] prdata;
		logic        pslverr;
	} rcst_regs_t;

endpackage : rcst_pkg

/* verilog/rcst_top.sv */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// [R1] Distinguish six reset causes, each recorded
// [R2] Defaults load on all resets except watchdog wake
// [R3] Unreset bits keep value except power-on
// [R4] Master clear filters short low pulses
// [R5] Power-on reset only on rising supply
// [R6] Power-up timer 72 ms after power-on/brown-out
// [R7] Disable bit set turns power-up timer off
// [R8] Configure power-up timer on whenever brown-out on
// [R9] Oscillator timer counts 1024 cycles after power-up timer
// [R10] Oscillator timer only crystal modes, power-up, wake
// [R11] Total hold-off follows mode and configuration
// [R12] RC mode, timer off: no hold-off
// [R13] Power-on pulse, then power-up timer, then oscillator
// [R14] Timers ignore master clear; release then immediate
// [R15] Brown-out enable bit gates brown-out detection
// [R16] Hold during brown-out, then power-up timer
// [R17] Recurring brown-out restarts power-up timer
// [R18] Brown-out flag bit0, hardware clears on brown-out
// [R19] Brown-out flag meaningless when detection disabled
// [R20] Power-on flag bit1 cleared on power-on only
// [R21] Timeout and sleep flags set per cause
// [R22] Power-on always sets both timeout and sleep
// [R23] Resets zero program counter, wakes resume
// [R24] Two bits select one of four clock modes
// [R25] Release needs pin high, no brown-out, timers done
module rcst_top
	import rcst_pkg::*;
#(
	parameter int unsigned POWER_UP_TIMER_TICKS = POWER_UP_TIMER_TICKS_DEF,
	parameter int unsigned RC_DIV     = RC_DIV_DEF
) (
	input  wire logic          clock,
	input  wire logic          sys_rst,
	input  wire rcst_apb_req_t apb_req,
	output rcst_apb_rsp_t      apb_rsp,
	input  wire rcst_cfg_t     cfg,
	input  wire logic          por_pulse,
	input  wire logic          brownout_detect,
	input  wire logic          master_clear_pin_n,
	input  wire logic          osc_in,
	input  wire logic          watchdog_timeout,
	input  wire logic          interrupt_wake,
	input  wire logic          core_sleeping,
	output logic               core_reset,
	output logic               core_wake_hold,
	output logic               wake_resume,
	output logic               timeout_flag,
	output logic               sleep_flag,
	output logic [2:0]         reset_cause
);

	rcst_regs_t r_q;
	rcst_regs_t r_d;
	logic       crystal;
	logic       power_up_timer_on;
	logic       por_act;
	logic       bor_act;
	logic       osc_rise;
	logic       rc_tick;
	logic       setup;
	logic       access;
	logic [1:0] mode;

	// Clock mode decode and start-up selections
	assign mode     = {cfg.clock_mode_bit_high, cfg.clock_mode_bit_low};  // [R24]
	assign crystal  = (mode != MODE_RC);                                   // [R10]
	assign power_up_timer_on  = ~cfg.power_timer_disable_cfg;                        // [R7]
	assign por_act  = r_q.por_st;                                          // [R5]
	assign bor_act  = r_q.bor_st & cfg.brownout_enable_cfg;               // [R15]
	// Oscillator edge once the filtered level turns high; osc_in must stay well below clock/3
	assign osc_rise = (r_q.osc_s[1] == r_q.osc_s[2]) & r_q.osc_s[2] & ~r_q.osc_st;
	assign rc_tick  = (r_q.rc_div == 16'(RC_DIV - 1));
	assign setup    = apb_req.psel & ~apb_req.penable;
	assign access   = apb_req.psel & apb_req.penable;

	// Next state of the whole block
	always_comb begin
		rcst_state_t after_hold;
		after_hold = ST_HOLD;
		r_d = r_q;
		r_d.wake_pulse = 1'b0;

		// Three-stage pin synchronisers; a change counts once stages two and three agree
		r_d.por_s  = {r_q.por_s[1:0], por_pulse};
		r_d.bor_s  = {r_q.bor_s[1:0], brownout_detect};
		r_d.master_clear_pin_s = {r_q.master_clear_pin_s[1:0], master_clear_pin_n};
		r_d.osc_s  = {r_q.osc_s[1:0], osc_in};
		if (r_q.por_s[1] == r_q.por_s[2]) begin
			r_d.por_st = r_q.por_s[2];
		end
		if (r_q.bor_s[1] == r_q.bor_s[2]) begin
			r_d.bor_st = r_q.bor_s[2];
		end
		if (r_q.master_clear_pin_s[1] == r_q.master_clear_pin_s[2]) begin
			r_d.master_clear_pin_st = r_q.master_clear_pin_s[2];
		end
		if (r_q.osc_s[1] == r_q.osc_s[2]) begin
			r_d.osc_st = r_q.osc_s[2];
		end

		// Master clear noise filter: low must persist filt_len cycles
		if (!r_q.master_clear_pin_st) begin
			if (r_q.filt_cnt != r_q.filt_len) begin
				r_d.filt_cnt = r_q.filt_cnt + 8'h01;                         // [R4]
			end else begin
				r_d.master_clear_pin_low = 1'b1;                                         // [R4]
			end
		end else begin
			r_d.filt_cnt = 8'h00;
			r_d.master_clear_pin_low = 1'b0;
		end

		// Internal RC time base for the power-up timer
		r_d.rc_div = rc_tick ? 16'h0000 : r_q.rc_div + 16'h0001;

		// Where a power-on or brown-out sequence goes after its pulse
		if (power_up_timer_on) begin
			after_hold = ST_POWER_UP_TIMER;                                            // [R6] [R13]
		end else if (crystal) begin
			after_hold = ST_OST;                                             // [R11]
		end else begin
			after_hold = ST_HOLD;                                            // [R12]
		end

		// Sequencer; power-on beats brown-out beats everything else
		if (por_act) begin
			r_d.state        = ST_POR;
			r_d.timeout_flag = 1'b1;                                         // [R21] [R22]
			r_d.sleep_flag   = 1'b1;                                         // [R21] [R22]
			r_d.por_flag     = 1'b0;                                         // [R20]
			r_d.cause        = CAUSE_POR;                                    // [R1]
			r_d.wake         = 1'b0;
		end else if (bor_act) begin
			r_d.state         = ST_BOR;                                      // [R16] [R17]
			r_d.brownout_flag = 1'b0;                                        // [R18]
			r_d.timeout_flag  = 1'b1;
			r_d.sleep_flag    = 1'b1;
			r_d.cause         = CAUSE_BOR;                                   // [R1] [R22]
			r_d.wake          = 1'b0;
		end else begin
			case (r_q.state)
				ST_POR, ST_BOR: begin
					r_d.state    = after_hold;                               // [R13] [R16]
					r_d.power_up_timer_cnt = 32'h0000_0000;                            // [R17]
					r_d.ost_cnt  = 11'h000;
				end
				ST_POWER_UP_TIMER: begin
					if (rc_tick) begin
						if (r_q.power_up_timer_cnt == 32'(POWER_UP_TIMER_TICKS - 1)) begin
							r_d.state   = crystal ? ST_OST : ST_HOLD;        // [R9] [R11]
							r_d.ost_cnt = 11'h000;
						end else begin
							r_d.power_up_timer_cnt = r_q.power_up_timer_cnt + 32'h0000_0001;     // [R6]
						end
					end
				end
				ST_OST: begin
					if (r_q.wake && r_q.master_clear_pin_low) begin
						// Master clear while waiting for the oscillator after a wake
						r_d.state        = ST_HOLD;
						r_d.wake         = 1'b0;
						r_d.timeout_flag = 1'b1;                             // [R21]
						r_d.sleep_flag   = 1'b0;
						r_d.cause        = CAUSE_MASTER_CLEAR_PIN_SLP;                   // [R1]
					end else if (osc_rise) begin
						if (r_q.ost_cnt == OST_LAST) begin
							if (r_q.wake) begin
								r_d.state      = ST_RUN;                     // [R23]
								r_d.wake       = 1'b0;
								r_d.wake_pulse = 1'b1;
							end else begin
								r_d.state = ST_HOLD;                         // [R9]
							end
						end else begin
							r_d.ost_cnt = r_q.ost_cnt + 11'h001;             // [R9]
						end
					end
				end
				ST_HOLD: begin
					if (!r_q.master_clear_pin_low) begin
						r_d.state = ST_RUN;                                  // [R14] [R25]
					end
				end
				ST_RUN: begin
					if (r_q.master_clear_pin_low) begin
						r_d.state = ST_HOLD;                                 // [R2]
						if (core_sleeping) begin
							r_d.timeout_flag = 1'b1;                         // [R21]
							r_d.sleep_flag   = 1'b0;
							r_d.cause        = CAUSE_MASTER_CLEAR_PIN_SLP;               // [R1]
						end else begin
							r_d.cause = CAUSE_MASTER_CLEAR_PIN_RUN;                      // [R1] [R21]
						end
					end else if (watchdog_timeout && !core_sleeping) begin
						r_d.state        = ST_HOLD;                          // [R2] [R23]
						r_d.timeout_flag = 1'b0;                             // [R21]
						r_d.sleep_flag   = 1'b1;
						r_d.cause        = CAUSE_WDT_RST;                    // [R1]
					end else if (core_sleeping && (watchdog_timeout || interrupt_wake)) begin
						r_d.timeout_flag = ~watchdog_timeout;                // [R21]
						r_d.sleep_flag   = 1'b0;
						r_d.cause        = watchdog_timeout ? CAUSE_WDT_WAKE : CAUSE_INT_WAKE;
						if (crystal) begin
							r_d.state   = ST_OST;                            // [R10]
							r_d.wake    = 1'b1;
							r_d.ost_cnt = 11'h000;
						end else begin
							r_d.wake_pulse = 1'b1;                           // [R2] [R23]
						end
					end
				end
				default: begin
					r_d.state = ST_POR;
				end
			endcase
		end

		// APB writes; a hardware clear in the same cycle wins over software
		if (access && apb_req.pwrite) begin
			case (apb_req.paddr)
				ADR_PWR_STATUS: begin
					if (!bor_act && !por_act) begin
						r_d.brownout_flag = apb_req.pwdata[PS_BO_BIT];       // [R18] [R19]
					end
					if (!por_act) begin
						r_d.por_flag = apb_req.pwdata[PS_POR_BIT];           // [R20]
					end
				end
				ADR_CTRL: begin
					r_d.filt_len = apb_req.pwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// Read data and error captured in the setup phase
		if (setup) begin
			r_d.pslverr = 1'b0;
			case (apb_req.paddr)
				ADR_PWR_STATUS: begin
					r_d.prdata = {30'h0, r_q.por_flag, r_q.brownout_flag};
				end
				ADR_CAUSE: begin
					r_d.prdata = {19'h0, r_q.state, r_q.wake, r_q.master_clear_pin_low,
						r_q.sleep_flag, r_q.timeout_flag, r_q.cause};
				end
				ADR_CTRL: begin
					r_d.prdata = {24'h0, r_q.filt_len};
				end
				default: begin
					r_d.prdata  = 32'h0000_0000;
					r_d.pslverr = 1'b1;
				end
			endcase
		end
	end

	// State register; flags without a defined power-on value still get a constant here
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_q              <= '0;                                          // [R3]
			r_q.master_clear_pin_s       <= 3'h7;
			r_q.master_clear_pin_st      <= 1'b1;
			r_q.state        <= ST_POR;
			r_q.timeout_flag <= 1'b1;
			r_q.sleep_flag   <= 1'b1;
			r_q.cause        <= CAUSE_POR;
			r_q.filt_len     <= MASTER_CLEAR_PIN_FILT_DEF;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs: core held unless running or waiting out a wake
	assign core_reset     = (r_q.state != ST_RUN) & ~(r_q.state == ST_OST & r_q.wake); // [R25]
	assign core_wake_hold = (r_q.state == ST_OST) & r_q.wake;
	assign wake_resume    = r_q.wake_pulse;                              // [R23]
	assign timeout_flag   = r_q.timeout_flag;
	assign sleep_flag     = r_q.sleep_flag;
	assign reset_cause    = r_q.cause;
	assign apb_rsp = '{pready:  access,
		pslverr: access & r_q.pslverr,
		prdata:  r_q.prdata};

	// Power-on leaves both flags set and power-on flag clear
	a_por_sets_flags: assert property (@(posedge clock) disable iff (sys_rst) // [R21]
		por_act |=> (r_q.timeout_flag && r_q.sleep_flag && !r_q.por_flag
			&& r_q.cause == CAUSE_POR))
		else $error("power-on flags wrong");

	a_bor_clears_flag: assert property (@(posedge clock) disable iff (sys_rst) // [R18]
		(bor_act && !por_act) |=> (!r_q.brownout_flag && r_q.state == ST_BOR))
		else $error("brown-out did not clear flag");

	a_wake_no_reset: assert property (@(posedge clock) disable iff (sys_rst) // [R2]
		(r_q.state == ST_RUN && core_sleeping && watchdog_timeout && !r_q.master_clear_pin_low
			&& !por_act && !bor_act) |=> (!core_reset && r_q.cause == CAUSE_WDT_WAKE
			&& !r_q.timeout_flag && !r_q.sleep_flag))
		else $error("watchdog wake disturbed state");

	a_master_clear_pin_run_flags: assert property (@(posedge clock) disable iff (sys_rst) // [R21]
		(r_q.state == ST_RUN && r_q.master_clear_pin_low && !core_sleeping && !por_act && !bor_act)
		|=> ($stable(r_q.timeout_flag) && $stable(r_q.sleep_flag) && core_reset))
		else $error("master clear changed flags");

	a_release_cond: assert property (@(posedge clock) disable iff (sys_rst) // [R25]
		(r_q.state == ST_HOLD && !r_q.master_clear_pin_low && !por_act && !bor_act)
		|=> (r_q.state == ST_RUN && !core_reset))
		else $error("release not immediate");

	a_power_up_timer_order: assert property (@(posedge clock) disable iff (sys_rst) // [R13]
		(r_q.state == ST_POR && !por_act && !bor_act && power_up_timer_on)
		|=> (r_q.state == ST_POWER_UP_TIMER && r_q.power_up_timer_cnt == 32'h0000_0000))
		else $error("power-up timer not started");

	a_rc_no_delay: assert property (@(posedge clock) disable iff (sys_rst) // [R12]
		(r_q.state == ST_POR && !por_act && !bor_act && !power_up_timer_on && !crystal)
		|=> r_q.state == ST_HOLD)
		else $error("hold-off in RC mode");

	a_ost_done: assert property (@(posedge clock) disable iff (sys_rst) // [R9]
		(r_q.state == ST_OST && !r_q.wake && osc_rise && r_q.ost_cnt == OST_LAST
			&& !por_act && !bor_act) |=> r_q.state == ST_HOLD)
		else $error("oscillator timer end missed");

	a_bor_restart: assert property (@(posedge clock) disable iff (sys_rst) // [R17]
		(r_q.state == ST_POWER_UP_TIMER && bor_act && !por_act) |=> r_q.state == ST_BOR)
		else $error("brown-out did not restart timer");

	// Leaving brown-out always clears the power-up timer count
	a_bor_exit_clear: assert property (@(posedge clock) disable iff (sys_rst) // [R17]
		(r_q.state == ST_BOR && !bor_act && !por_act)
		|=> (r_q.power_up_timer_cnt == 32'h0000_0000 && r_q.state != ST_BOR))
		else $error("brown-out exit kept timer count");

	a_bor_gated: assert property (@(posedge clock) disable iff (sys_rst) // [R15]
		(!cfg.brownout_enable_cfg && !por_act) |=> r_q.state != ST_BOR)
		else $error("disabled brown-out caused reset");

	a_filter_glitch: assert property (@(posedge clock) disable iff (sys_rst) // [R4]
		$rose(r_q.master_clear_pin_low) |-> ($past(r_q.filt_cnt) == $past(r_q.filt_len)
			&& !$past(r_q.master_clear_pin_st)))
		else $error("master clear passed filter early");

	// Timeout and sleep flags for watchdog reset, master clear in sleep and interrupt wake; cause for a clear during a wake
	a_wdt_reset_flags: assert property (@(posedge clock) disable iff (sys_rst) // [R21]
		(r_q.state == ST_RUN && !core_sleeping && watchdog_timeout && !r_q.master_clear_pin_low
			&& !por_act && !bor_act) |=> (core_reset && !r_q.timeout_flag
			&& r_q.sleep_flag && r_q.cause == CAUSE_WDT_RST))
		else $error("watchdog reset flags wrong");

	a_master_clear_pin_sleep_flags: assert property (@(posedge clock) disable iff (sys_rst) // [R21]
		(r_q.state == ST_RUN && core_sleeping && r_q.master_clear_pin_low && !por_act && !bor_act)
		|=> (core_reset && r_q.timeout_flag && !r_q.sleep_flag
			&& r_q.cause == CAUSE_MASTER_CLEAR_PIN_SLP))
		else $error("sleep master clear flags wrong");

	a_int_wake_flags: assert property (@(posedge clock) disable iff (sys_rst) // [R23]
		(r_q.state == ST_RUN && core_sleeping && interrupt_wake && !watchdog_timeout
			&& !r_q.master_clear_pin_low && !por_act && !bor_act) |=> (!core_reset
			&& r_q.timeout_flag && !r_q.sleep_flag && r_q.cause == CAUSE_INT_WAKE))
		else $error("interrupt wake flags wrong");

	a_wake_master_clear_pin_cut: assert property (@(posedge clock) disable iff (sys_rst) // [R1]
		(r_q.state == ST_OST && r_q.wake && r_q.master_clear_pin_low && !por_act && !bor_act)
		|=> (core_reset && !core_wake_hold && r_q.cause == CAUSE_MASTER_CLEAR_PIN_SLP))
		else $error("clear during wake not taken");

	// Software write to power status lands unless hardware clears it
	a_status_write: assert property (@(posedge clock) disable iff (sys_rst) // [R20]
		(access && apb_req.pwrite && apb_req.paddr == ADR_PWR_STATUS
			&& !por_act && !bor_act)
		|=> (r_q.por_flag == $past(apb_req.pwdata[PS_POR_BIT])
			&& r_q.brownout_flag == $past(apb_req.pwdata[PS_BO_BIT])))
		else $error("power status write lost");

	a_ost_edge_only: assert property (@(posedge clock) disable iff (sys_rst) // [R9]
		(r_q.state == ST_OST && !osc_rise) |=> $stable(r_q.ost_cnt))
		else $error("oscillator timer counted without edge");

endmodule : rcst_top

/* verif/rcst_supply_model.sv */
`timescale 1ns/1ps
// Far side: supply monitors, pulled-up master clear pin, crystal
module rcst_supply_model #(
	parameter int OSC_HALF = 4
) (
	input  wire logic clock,
	input  wire logic supply_up,
	input  wire logic supply_low,
	input  wire logic pin_pressed,
	output logic      por_pulse,
	output logic      brownout_detect,
	output logic      master_clear_pin_n,
	output logic      osc_in
);
	int osc_cnt = 0;

	// Detector pulses on a rising supply only; a fall shows as brown-out
	assign por_pulse          = supply_up;
	assign brownout_detect    = supply_low;
	// Pull-up takes the pin high once released
	assign master_clear_pin_n = ~pin_pressed;

	// Free-running crystal, a few core clocks per half period
	initial osc_in = 1'b0;
	always @(posedge clock) begin
		osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
		if (osc_cnt == OSC_HALF - 1) begin
			osc_in <= ~osc_in;
		end
	end
endmodule : rcst_supply_model

/* verif/rcst_top_bench.sv */
`timescale 1ns/1ps
module rcst_top_bench
	import rcst_pkg::*;
;
	localparam int PT = 50;
	localparam int RD = 2;
	localparam int OP = 8;
	localparam int OST_CLK = (OST_CYCLES - 1) * OP;

	logic          clock = 1'b0;
	logic          sys_rst = 1'b1;
	rcst_apb_req_t req = '0;
	rcst_apb_rsp_t rsp;
	rcst_cfg_t     cfg = 4'h4;
	logic          sup_up = 1'b0;
	logic          sup_low = 1'b0;
	logic          press = 1'b0;
	logic          wdt = 1'b0;
	logic          intr = 1'b0;
	logic          sleeping = 1'b0;
	logic          por_p, low_det, pin_n, osc, core_reset, hold, resume, tmo_f, slp_f;
	logic [2:0]    cause;
	logic [31:0]   rd;
	logic          er;
	int            err_count = 0;
	int            total_checks = 0;
	int            seed = 32'hc7e9;
	int            cyc = 0;
	int            c, i;

	// Free-running bench clock
	always #5 clock = ~clock;

	rcst_top #(.POWER_UP_TIMER_TICKS(PT), .RC_DIV(RD)) rcst_top_i (
		.clock(clock), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp), .cfg(cfg),
		.por_pulse(por_p), .brownout_detect(low_det), .master_clear_pin_n(pin_n),
		.osc_in(osc), .watchdog_timeout(wdt), .interrupt_wake(intr),
		.core_sleeping(sleeping), .core_reset(core_reset), .core_wake_hold(hold),
		.wake_resume(resume), .timeout_flag(tmo_f), .sleep_flag(slp_f), .reset_cause(cause)
	);

	rcst_supply_model #(.OSC_HALF(OP / 2)) rcst_supply_model_i (
		.clock(clock), .supply_up(sup_up), .supply_low(sup_low), .pin_pressed(press),
		.por_pulse(por_p), .brownout_detect(low_det), .master_clear_pin_n(pin_n),
		.osc_in(osc)
	);

	// Verdict and end of run
	task final_report;
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Cycle count must fall inside a window
	task chk_in(input int v, input int lo, input int hi);
		chk(32'(v >= lo && v <= hi), 32'h1);
	endtask : chk_in

	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			err_count++;
			final_report;
		end
	end

	task tick(input int k);
		repeat (k) @(posedge clock);
	endtask : tick

	// Wait for core_reset to reach a level, counting cycles
	task wait_rst(input logic lvl);
		c = 0;
		while (core_reset !== lvl && c < 20000) begin
			@(negedge clock);
			c++;
		end
	endtask : wait_rst

	// One APB transfer: setup, then access until pready
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clock);
		req.penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask : apb

	// Power-on pulse, then hold-off measured against mode and timer setting
	task power_on(input logic [1:0] m, input logic off);
		int lo;
		lo = (off ? 0 : PT * RD) + (m == MODE_RC ? 0 : OST_CLK);
		@(posedge clock);
		cfg    <= '{off, ~off, m[1], m[0]};
		sup_up <= 1'b1;
		tick(6);
		sup_up <= 1'b0;
		wait_rst(1'b0);
		chk_in(c, lo, lo + 40);
		chk({tmo_f, slp_f, cause}, {2'b11, CAUSE_POR});
	endtask : power_on

	// Long press of the clear pin, awake or asleep
	task pin_reset(input logic slp, input logic [4:0] exp);
		@(posedge clock);
		sleeping <= slp;
		press    <= 1'b1;
		tick(40);
		press    <= 1'b0;
		@(negedge clock);
		chk(core_reset, 1'b1);
		wait_rst(1'b0);
		chk_in(c, 0, 40);
		chk({tmo_f, slp_f, cause}, exp);
		@(posedge clock);
		sleeping <= 1'b0;
	endtask : pin_reset

	initial begin
		tick(4);
		sys_rst <= 1'b0;
		// Every clock mode with the timer on, then two with it off
		for (i = 0; i < 6; i++) begin
			power_on(i[1:0] ^ {i[2], i[2]}, i[2]);
		end
		// Brown-out detection switched off
		@(posedge clock);
		sup_low <= 1'b1;
		tick(20);
		sup_low <= 1'b0;
		@(negedge clock);
		chk(core_reset, 1'b0);
		// Pin held low through the whole start-up, then released
		@(posedge clock);
		cfg    <= 4'h5;
		press  <= 1'b1;
		sup_up <= 1'b1;
		tick(6);
		sup_up <= 1'b0;
		tick(PT * RD + OST_CYCLES * OP + 100);
		press <= 1'b0;
		@(negedge clock);
		chk(core_reset, 1'b1);
		wait_rst(1'b0);
		chk_in(c, 0, 40);
		// Registers: reset values, unmapped place, power status
		apb(1'b0, ADR_CTRL, 32'h0);
		chk(rd, {24'h0, MASTER_CLEAR_PIN_FILT_DEF});
		apb(1'b0, 12'h400, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b0, ADR_PWR_STATUS, 32'h0);
		chk({31'h0, rd[1]}, 32'h0);
		apb(1'b1, ADR_PWR_STATUS, 32'h3);
		apb(1'b0, ADR_PWR_STATUS, 32'h0);
		chk(rd, 32'h3);
		// Random short pin glitches are filtered out
		repeat (6) begin
			@(posedge clock);
			press <= 1'b1;
			tick(1 + {$random(seed)} % 12);
			press <= 1'b0;
			tick(30);
			@(negedge clock);
			chk({core_reset, cause}, {1'b0, CAUSE_POR});
		end
		// Watchdog reset while awake
		@(posedge clock);
		wdt <= 1'b1;
		@(posedge clock);
		wdt <= 1'b0;
		@(negedge clock);
		chk({core_reset, tmo_f, slp_f, cause}, {3'b101, CAUSE_WDT_RST});
		wait_rst(1'b0);
		apb(1'b0, ADR_PWR_STATUS, 32'h0);
		chk(rd, 32'h3);
		pin_reset(1'b0, {2'b01, CAUSE_MASTER_CLEAR_PIN_RUN});
		// Watchdog wake from sleep: no reset, oscillator timer only
		@(posedge clock);
		sleeping <= 1'b1;
		wdt      <= 1'b1;
		@(posedge clock);
		wdt <= 1'b0;
		@(negedge clock);
		chk({core_reset, hold, tmo_f, slp_f, cause}, {4'b0100, CAUSE_WDT_WAKE});
		c = 0;
		while (resume !== 1'b1 && c < 20000) begin
			@(negedge clock);
			c++;
		end
		chk_in(c, OST_CLK, OST_CLK + 40);
		chk(core_reset, 1'b0);
		@(posedge clock);
		sleeping <= 1'b0;
		pin_reset(1'b1, {2'b10, CAUSE_MASTER_CLEAR_PIN_SLP});
		// Interrupt wake, cut short by the clear pin during the oscillator wait
		@(posedge clock);
		sleeping <= 1'b1;
		intr     <= 1'b1;
		@(posedge clock);
		intr <= 1'b0;
		@(negedge clock);
		chk({core_reset, hold, tmo_f, slp_f, cause}, {4'b0110, CAUSE_INT_WAKE});
		pin_reset(1'b1, {2'b10, CAUSE_MASTER_CLEAR_PIN_SLP});
		// Brown-out, recurring while the power-up timer runs
		@(posedge clock);
		sup_low <= 1'b1;
		tick(20);
		sup_low <= 1'b0;
		@(negedge clock);
		chk({core_reset, tmo_f, slp_f, cause}, {3'b111, CAUSE_BOR});
		tick(50);
		sup_low <= 1'b1;
		tick(10);
		sup_low <= 1'b0;
		wait_rst(1'b0);
		chk_in(c, PT * RD + OST_CLK, PT * RD + OST_CLK + 40);
		apb(1'b0, ADR_PWR_STATUS, 32'h0);
		chk(rd, 32'h2);
		final_report;
	end
endmodule : rcst_top_bench
